// File: src/bpm_cfg_regs.sv
// Bridge diagnostic register and power-management capability item, two functions
`timescale 1ns/1ps
`default_nettype none
`include "bpm_defs.svh"
module bpm_cfg_regs #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Configuration access
  input wire logic cfg_req_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_func_i,
  input wire bpm_pkg::bpm_dw_t cfg_dw_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  // Socket status change, one per function
  input wire bpm_pkg::bpm_func_vec_t status_change_i,
  input wire bpm_pkg::bpm_func_vec_t legacy_int_bit4_i,
  input wire bpm_pkg::bpm_route_t legacy_route0_i,
  input wire bpm_pkg::bpm_route_t legacy_route1_i,
  output bpm_pkg::bpm_func_vec_t csc_pci_irq_o,
  // Controls for the bridge datapath
  output logic delayed_txn_disable_o,
  output bpm_pkg::bpm_retry_t retry_limit_o,
  output bpm_pkg::bpm_count_t card_side_discard_length_o,
  output bpm_pkg::bpm_count_t host_side_discard_length_o,
  output bpm_pkg::bpm_func_vec_t video_port_model_disable_o,
  output logic [9:0] wake_state_support_o
);
  import bpm_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  function automatic bpm_count_t disc_len(input logic short_sel);
    disc_len = short_sel ? bpm_count_t'(1 << `BPM_DISC_LOG2_SHORT)
                         : bpm_count_t'(1 << `BPM_DISC_LOG2_LONG);
  endfunction

  function automatic logic [15:0] pmc_value(input logic wake_cold);
    logic [15:0] v;
    v = `BPM_PMC_RST;
    v[`BPM_PMC_WAKE_COLD] = wake_cold;
    pmc_value = v;
  endfunction

  // Global diagnostic bits, held once for both functions
  logic id_mask;
  logic delayed_txn_disable;
  logic retry_latency_extend;
  logic secondary_discard_timer_select;
  logic primary_discard_timer_select;

  wire bpm_dw_t dw_id;
  wire bpm_dw_t dw_diag;
  wire bpm_dw_t dw_cap;
  wire logic wr_any;
  wire logic rd_any;
  wire logic wr_diag;
  wire logic wr_diag_global;
  wire logic wr_pmc_hi;
  wire logic [1:0] wr_diag_f;
  wire logic [1:0] wr_pmc_f;
  wire logic [1:0] csc_sel;
  wire logic [1:0] vid_dis;
  wire logic [1:0] wake_cold;
  wire bpm_route_t legacy_route [2];
  wire logic [3:0] glob_rd;
  wire logic [7:0] diag_rd;
  wire logic [15:0] pmc_rd;
  wire logic [31:0] next_rdata;
  wire bpm_retry_t next_retry;
  wire logic [15:0] pmc_func0;
  wire logic [15:0] pmc_func1;

  // Byte offsets fit in eight bits, so the dword index keeps the upper six
  assign dw_id = bpm_dw_t'(`BPM_OFF_ID >> 2);
  assign dw_diag = bpm_dw_t'(`BPM_OFF_DIAG >> 2);
  assign dw_cap = bpm_dw_t'(`BPM_OFF_CAPID >> 2);

  assign wr_any = cfg_req_i && cfg_wr_i;
  assign rd_any = cfg_req_i && !cfg_wr_i;
  // Only the writable lanes are decoded; all other lanes are dropped
  assign wr_diag = wr_any && (cfg_dw_i == dw_diag) && cfg_be_i[`BPM_LANE_DIAG];
  assign wr_pmc_hi = wr_any && (cfg_dw_i == dw_cap) && cfg_be_i[`BPM_LANE_PMC_HI];
  assign wr_diag_global = wr_diag && !cfg_func_i;
  assign wr_diag_f = {wr_diag && cfg_func_i, wr_diag && !cfg_func_i};
  assign wr_pmc_f = {wr_pmc_hi && cfg_func_i, wr_pmc_hi && !cfg_func_i};
  assign legacy_route[0] = legacy_route0_i;
  assign legacy_route[1] = legacy_route1_i;

  genvar f;
  generate
    for (f = 0; f < 2; f++) begin : g_func
      bpm_func_regs u_func (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_diag_i(wr_diag_f[f]),
        .wr_pmc_hi_i(wr_pmc_f[f]),
        .wdata_i(cfg_wdata_i[31:24]),
        .status_change_i(status_change_i[f]),
        .legacy_int_bit4_i(legacy_int_bit4_i[f]),
        .legacy_route_i(legacy_route[f]),
        .csc_sel_o(csc_sel[f]),
        .vid_dis_o(vid_dis[f]),
        .wake_cold_o(wake_cold[f]),
        .csc_irq_o(csc_pci_irq_o[f])
      );
    end
  endgenerate

  // Function 1 sees the global bits as zero so it cannot mirror function 0
  assign glob_rd = cfg_func_i ? 4'h0 : {delayed_txn_disable, retry_latency_extend,
                                        secondary_discard_timer_select,
                                        primary_discard_timer_select};
  assign diag_rd = {id_mask && !cfg_func_i, 1'b1, csc_sel[cfg_func_i], glob_rd,
                    vid_dis[cfg_func_i]};
  assign pmc_rd = pmc_value(wake_cold[cfg_func_i]);
  assign pmc_func0 = pmc_value(wake_cold[0]);
  assign pmc_func1 = pmc_value(wake_cold[1]);

  // The mask is global, so it hides the identifiers of both functions
  assign next_rdata = (cfg_dw_i == dw_id) ? (id_mask ? 32'hffff_ffff
                                                      : {DEVICE_ID, VENDOR_ID}) :
                      (cfg_dw_i == dw_diag) ? {diag_rd, 24'h00_0000} :
                      (cfg_dw_i == dw_cap) ? {pmc_rd, `BPM_NEXT_VAL, `BPM_CAPID_VAL} :
                      32'h0000_0000;

  assign next_retry = retry_latency_extend ? `BPM_RETRY_LONG : `BPM_RETRY_SHORT;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      id_mask <= 1'b0;
      delayed_txn_disable <= 1'b0;
      retry_latency_extend <= 1'b0;
      secondary_discard_timer_select <= 1'b0;
      primary_discard_timer_select <= 1'b0;
    end else if (wr_diag_global) begin
      id_mask <= cfg_wdata_i[24 + `BPM_DIAG_ID_MASK];
      delayed_txn_disable <= cfg_wdata_i[24 + `BPM_DIAG_DTD];
      retry_latency_extend <= cfg_wdata_i[24 + `BPM_DIAG_RETRY];
      secondary_discard_timer_select <= cfg_wdata_i[24 + `BPM_DIAG_CB_DISC];
      primary_discard_timer_select <= cfg_wdata_i[24 + `BPM_DIAG_PCI_DISC];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_ack_o <= cfg_req_i;
      cfg_rdata_o <= rd_any ? next_rdata : 32'h0000_0000;
    end
  end

  // Datapath controls are registered copies, one cycle behind the register bits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      delayed_txn_disable_o <= 1'b0;
      retry_limit_o <= `BPM_RETRY_SHORT;
      card_side_discard_length_o <= bpm_count_t'(1 << `BPM_DISC_LOG2_LONG);
      host_side_discard_length_o <= bpm_count_t'(1 << `BPM_DISC_LOG2_LONG);
      video_port_model_disable_o <= 2'b00;
      wake_state_support_o <= 10'h3ff;
    end else begin
      delayed_txn_disable_o <= delayed_txn_disable;
      retry_limit_o <= next_retry;
      card_side_discard_length_o <= disc_len(secondary_discard_timer_select);
      host_side_discard_length_o <= disc_len(primary_discard_timer_select);
      video_port_model_disable_o <= vid_dis;
      wake_state_support_o <= {pmc_func1[15:11], pmc_func0[15:11]};
    end
  end

  a_id_masked_read: assert property (
    (rd_any && cfg_dw_i == dw_id && id_mask) |=> (cfg_ack_o && cfg_rdata_o == 32'hffff_ffff))
    else $error("Masked identifier read did not return all ones");
  a_id_true_read: assert property (
    (rd_any && cfg_dw_i == dw_id && !id_mask) |=> (cfg_rdata_o == {DEVICE_ID, VENDOR_ID}))
    else $error("Unmasked identifier read did not return true identifiers");
  a_diag_rsvd_one: assert property (
    (rd_any && cfg_dw_i == dw_diag) |=> cfg_rdata_o[24 + `BPM_DIAG_RSVD])
    else $error("Diagnostic reserved bit read as zero");
  a_dtd_follows: assert property (
    (wr_diag_global && cfg_wdata_i[24 + `BPM_DIAG_DTD]) |-> ##2 delayed_txn_disable_o)
    else $error("Delayed transaction disable did not follow the write");
  a_retry_limit_val: assert property (
    ##1 (retry_limit_o == ($past(retry_latency_extend) ? 7'd64 : 7'd16)))
    else $error("Retry limit does not match the extend bit");
  a_card_discard_len: assert property (
    ##1 (card_side_discard_length_o ==
         ($past(secondary_discard_timer_select) ? 16'h0400 : 16'h8000)))
    else $error("Card-side discard length wrong");
  a_host_discard_len: assert property (
    ##1 (host_side_discard_length_o ==
         ($past(primary_discard_timer_select) ? 16'h0400 : 16'h8000)))
    else $error("Host-side discard length wrong");
  a_func1_no_global: assert property (
    (wr_diag && cfg_func_i) |=> ($stable(id_mask) && $stable(retry_latency_extend)
                                 && $stable(delayed_txn_disable)))
    else $error("Function 1 write changed a global bit");
  a_cap_item_read: assert property (
    (rd_any && cfg_dw_i == dw_cap) |=> (cfg_rdata_o[15:0] == 16'h0001))
    else $error("Capability identifier or next pointer wrong");
  a_pmc_fixed_bits: assert property (
    (rd_any && cfg_dw_i == dw_cap) |=> (cfg_rdata_o[30:25] == 6'h3f
                                        && cfg_rdata_o[18:16] == 3'b010))
    else $error("Read-only capability bits wrong");
  a_pmc_wake_read: assert property (
    (rd_any && cfg_dw_i == dw_cap) |=> (cfg_rdata_o[31] == wake_cold[$past(cfg_func_i)]))
    else $error("Cold-off wake bit read back wrong");
  a_wake_ro_ones: assert property (
    (wake_state_support_o[8:5] == 4'hf) && (wake_state_support_o[3:0] == 4'hf))
    else $error("Read-only wake support bits not all ones");
  a_ack_one_cycle: assert property (
    cfg_req_i |=> cfg_ack_o)
    else $error("Configuration request not acknowledged one cycle later");
  a_ack_no_request: assert property (
    !cfg_req_i |=> (!cfg_ack_o && cfg_rdata_o == 32'h0000_0000))
    else $error("Acknowledge or read data without a request");
  a_unmapped_read: assert property (
    (rd_any && cfg_dw_i != dw_id && cfg_dw_i != dw_diag && cfg_dw_i != dw_cap)
      |=> (cfg_rdata_o == 32'h0000_0000))
    else $error("Unmapped configuration read returned nonzero data");
  a_lane_write_ignored: assert property (
    (wr_any && cfg_dw_i == dw_diag && !cfg_be_i[`BPM_LANE_DIAG])
      |=> ($stable(id_mask) && $stable(csc_sel) && $stable(vid_dis)))
    else $error("Diagnostic write on a disabled lane changed the register");
  a_func1_read_global: assert property (
    (rd_any && cfg_dw_i == dw_diag && cfg_func_i)
      |=> ((cfg_rdata_o[31:24] & 8'h9e) == 8'h00))
    else $error("Function 1 diagnostic read showed a global bit");
  a_video_follows: assert property (
    wr_diag_f[0] |-> ##2 (video_port_model_disable_o[0] ==
                          $past(cfg_wdata_i[24 + `BPM_DIAG_VID], 2)))
    else $error("Video model disable did not follow the write");
endmodule
`default_nettype wire

// File: shared/bpm_defs.svh
// Offsets, field positions, reset values and counts of the bridge diagnostic/PM registers
`ifndef BPM_DEFS_SVH
`define BPM_DEFS_SVH

// Byte offsets in configuration space
`define BPM_OFF_ID 8'h00
`define BPM_OFF_DIAG 8'h93
`define BPM_OFF_CAPID 8'ha0
`define BPM_OFF_NEXT 8'ha1
`define BPM_OFF_PMC 8'ha2

// Byte lane of each register inside its dword
`define BPM_LANE_DIAG 3
`define BPM_LANE_PMC_HI 3

// Diagnostic register fields
`define BPM_DIAG_ID_MASK 7
`define BPM_DIAG_RSVD 6
`define BPM_DIAG_CSC_SEL 5
`define BPM_DIAG_DTD 4
`define BPM_DIAG_RETRY 3
`define BPM_DIAG_CB_DISC 2
`define BPM_DIAG_PCI_DISC 1
`define BPM_DIAG_VID 0
`define BPM_DIAG_RST 8'h60
`define BPM_CSC_SEL_RST 1'b1

// Capability list values
`define BPM_CAPID_VAL 8'h01
`define BPM_NEXT_VAL 8'h00
`define BPM_PMC_RST 16'hfe12
`define BPM_PMC_WAKE_COLD 15

// Controls steered by the diagnostic bits
`define BPM_RETRY_SHORT 7'd16
`define BPM_RETRY_LONG 7'd64
`define BPM_DISC_LOG2_SHORT 10
`define BPM_DISC_LOG2_LONG 15
`define BPM_LEGACY_ROUTE_PCI 4'h0

`endif

// File: shared/bpm_pkg.sv
// Types shared by the bridge diagnostic/PM register block
`default_nettype none
package bpm_pkg;
  typedef logic [5:0] bpm_dw_t;
  typedef logic [1:0] bpm_func_vec_t;
  typedef logic [3:0] bpm_route_t;
  typedef logic [6:0] bpm_retry_t;
  typedef logic [15:0] bpm_count_t;
endpackage
`default_nettype wire

// File: src/bpm_func_regs.sv
// Per-function diagnostic bits, cold-off wake bit and status-change routing
`timescale 1ns/1ps
`default_nettype none
`include "bpm_defs.svh"
module bpm_func_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register writes
  input wire logic wr_diag_i,
  input wire logic wr_pmc_hi_i,
  input wire logic [7:0] wdata_i,
  // Socket status change
  input wire logic status_change_i,
  input wire logic legacy_int_bit4_i,
  input wire bpm_pkg::bpm_route_t legacy_route_i,
  // State
  output logic csc_sel_o,
  output logic vid_dis_o,
  output logic wake_cold_o,
  output logic csc_irq_o
);
  import bpm_pkg::*;

  wire logic route_ok;
  wire logic bit4_at_zero;

  // With select set the legacy bit 4 is a don't care
  assign route_ok = csc_sel_o ? (legacy_route_i == `BPM_LEGACY_ROUTE_PCI)
                              : legacy_int_bit4_i;
  assign bit4_at_zero = (legacy_route_i == `BPM_LEGACY_ROUTE_PCI) && !legacy_int_bit4_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      csc_sel_o <= `BPM_CSC_SEL_RST;
      vid_dis_o <= 1'b0;
      wake_cold_o <= 1'b1;
      csc_irq_o <= 1'b0;
    end else begin
      if (wr_diag_i) begin
        csc_sel_o <= wdata_i[`BPM_DIAG_CSC_SEL];
        vid_dis_o <= wdata_i[`BPM_DIAG_VID];
      end
      if (wr_pmc_hi_i) begin
        wake_cold_o <= wdata_i[`BPM_PMC_WAKE_COLD - 8];
      end
      csc_irq_o <= status_change_i && route_ok;
    end
  end

  a_route_select_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (csc_sel_o && status_change_i && bit4_at_zero) |=> csc_irq_o)
    else $error("Status change lost with select one and legacy field zero");
  a_route_select_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!csc_sel_o && status_change_i && !legacy_int_bit4_i) |=> !csc_irq_o)
    else $error("Status change routed although legacy bit 4 is clear");
  a_wake_cold_wr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_pmc_hi_i |=> (wake_cold_o == $past(wdata_i[`BPM_PMC_WAKE_COLD - 8])))
    else $error("Cold-off wake bit did not take the written value");
endmodule
`default_nettype wire

// File: testbench/bpm_host_model.sv
// Configuration host model issuing one-cycle requests to the register block
`timescale 1ns/1ps
`default_nettype none
module bpm_host_model (
  // Clock
  input wire logic clk_i,
  // Configuration access
  output logic cfg_req_o,
  output logic cfg_wr_o,
  output logic cfg_func_o,
  output bpm_pkg::bpm_dw_t cfg_dw_o,
  output logic [3:0] cfg_be_o,
  output logic [31:0] cfg_wdata_o,
  input wire logic cfg_ack_i,
  input wire logic [31:0] cfg_rdata_i
);
  import bpm_pkg::*;
  initial begin
    cfg_req_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_func_o = 1'b0;
    cfg_dw_o = 6'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h0;
  end
  // Request is a single-cycle pulse, dropped 1 ns after the taking edge, when the answer registered at that edge is read
  task automatic access(input logic wr, input logic fn, input bpm_dw_t dw,
      input logic [3:0] be, input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    cfg_req_o = 1'b1;
    cfg_wr_o = wr;
    cfg_func_o = fn;
    cfg_dw_o = dw;
    cfg_be_o = be;
    cfg_wdata_o = wd;
    @(posedge clk_i);
    #1;
    cfg_req_o = 1'b0;
    // Released data must not keep its old value
    cfg_wdata_o = ~wd;
    ack = cfg_ack_i;
    rd = cfg_rdata_i;
    @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_bridge_diag_and_pm_capability_regs.sv
// Self-checking bench of the bridge diagnostic and power-management registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_bridge_diag_and_pm_capability_regs;
  import bpm_pkg::*;
  localparam logic [15:0] VID = 16'h2a5c; // Arbitrary value
  localparam logic [15:0] DID = 16'h93e1; // Arbitrary value
  logic clk_i, rst_b_i, cfg_req, cfg_wr, cfg_func, cfg_ack, dtd, ack;
  bpm_dw_t cfg_dw;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, seed, rd;
  bpm_func_vec_t sc, lb4, irq, vid_dis;
  bpm_route_t r0, r1;
  bpm_retry_t retry;
  bpm_count_t cdisc, hdisc;
  logic [9:0] wake;
  logic [7:0] d0, d1;
  logic [1:0] cold;
  int error_cnt, num_checks, cycles;

  bpm_cfg_regs #(.VENDOR_ID(VID), .DEVICE_ID(DID)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .cfg_req_i(cfg_req), .cfg_wr_i(cfg_wr), .cfg_func_i(cfg_func), .cfg_dw_i(cfg_dw),
    .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata), .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata),
    .status_change_i(sc), .legacy_int_bit4_i(lb4), .legacy_route0_i(r0),
    .legacy_route1_i(r1), .csc_pci_irq_o(irq), .delayed_txn_disable_o(dtd),
    .retry_limit_o(retry), .card_side_discard_length_o(cdisc),
    .host_side_discard_length_o(hdisc), .video_port_model_disable_o(vid_dis),
    .wake_state_support_o(wake));
  bpm_host_model host_u (.clk_i(clk_i), .cfg_req_o(cfg_req), .cfg_wr_o(cfg_wr),
    .cfg_func_o(cfg_func), .cfg_dw_o(cfg_dw), .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata),
    .cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
  endfunction
  // Function 1 sees only its own bits; the global ones read as zero there
  function automatic logic [31:0] diag_exp(input logic fn);
    diag_exp = {(fn ? (d1 & 8'h21) : d0) | 8'h40, 24'h0};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic acc(input logic wr, input logic fn, input bpm_dw_t dw, input logic [3:0] be,
      input logic [31:0] wd);
    host_u.access(wr, fn, dw, be, wd, ack, rd);
    `CHK("ack", 1'b1, ack)
  endtask
  task automatic rd_chk(input logic fn, input bpm_dw_t dw, input logic [31:0] e);
    acc(1'b0, fn, dw, 4'h0, 32'h0);
    `CHK("rdata", e, rd)
  endtask
  task automatic wr_diag(input logic fn, input logic [7:0] w);
    acc(1'b1, fn, 6'h24, 4'h8, {w, 24'h0});
    if (fn) begin
      d1 = w;
    end else begin
      d0 = w;
    end
  endtask
  task automatic chk_ctrl();
    `CHK("dtd", d0[4], dtd)
    `CHK("retry", d0[3] ? 7'h40 : 7'h10, retry)
    `CHK("cdisc", d0[2] ? 16'h0400 : 16'h8000, cdisc)
    `CHK("hdisc", d0[1] ? 16'h0400 : 16'h8000, hdisc)
    `CHK("video", {d1[0], d0[0]}, vid_dis)
    `CHK("wake", {cold[1], 4'hf, cold[0], 4'hf}, wake)
  endtask
  task automatic csc_step();
    logic [1:0] e;
    seed = lfsr(seed);
    sc = seed[1:0];
    lb4 = seed[3:2];
    r0 = seed[4] ? 4'h0 : seed[11:8];
    r1 = seed[5] ? 4'h0 : seed[15:12];
    e[0] = sc[0] & (d0[5] ? r0 == 4'h0 : lb4[0]);
    e[1] = sc[1] & (d1[5] ? r1 == 4'h0 : lb4[1]);
    @(posedge clk_i);
    #1;
    `CHK("irq", e, irq)
  endtask
  task automatic reset_chk();
    d0 = 8'h60;
    d1 = 8'h60;
    cold = 2'b11;
    chk_ctrl();
    for (int f = 0; f < 2; f++) begin
      rd_chk(f[0], 6'h24, 32'h6000_0000);
      rd_chk(f[0], 6'h28, 32'hfe12_0001);
      rd_chk(f[0], 6'h00, {DID, VID});
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    rst_b_i = 1'b0;
    sc = 2'b00;
    lb4 = 2'b00;
    r0 = 4'h0;
    r1 = 4'h0;
    seed = 32'he82a;
    repeat (12) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    reset_chk();
    $display("reset values test done");
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      wr_diag(seed[8], seed[7:0]);
      chk_ctrl();
      rd_chk(seed[8], 6'h24, diag_exp(seed[8]));
      rd_chk(seed[9], 6'h00, d0[7] ? 32'hffff_ffff : {DID, VID});
      csc_step();
      csc_step();
    end
    $display("diagnostic and routing test done");
    for (int f = 0; f < 2; f++) begin
      acc(1'b1, f[0], 6'h28, 4'h7, 32'h0);
      rd_chk(f[0], 6'h28, 32'hfe12_0001);
      acc(1'b1, f[0], 6'h28, 4'hf, 32'h01ed_fffe);
      cold[f] = 1'b0;
      rd_chk(f[0], 6'h28, 32'h7e12_0001);
      chk_ctrl();
    end
    rd_chk(1'b0, 6'h3f, 32'h0);
    // Lanes other than the register's own, and read-only dwords, take no write
    acc(1'b1, 1'b0, 6'h24, 4'h7, 32'h00ff_ffff);
    rd_chk(1'b0, 6'h24, diag_exp(1'b0));
    acc(1'b1, 1'b0, 6'h00, 4'hf, 32'h0);
    rd_chk(1'b1, 6'h00, d0[7] ? 32'hffff_ffff : {DID, VID});
    $display("capability test done");
    wr_diag(1'b0, 8'h00);
    wr_diag(1'b1, 8'h00);
    chk_ctrl();
    rst_b_i = 1'b0;
    @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    reset_chk();
    $display("second reset test done");
    test_done();
  end
endmodule
`default_nettype wire
